/* tb/mcu_instruction_execute_subset_tb.sv */
`timescale 1ns/10ps
module mcu_instruction_execute_subset_tb;
  import mie_pkg::*;
  logic            sys_clk;
  logic            rst_n;
  logic            insValid;
  logic            insReady;
  logic            done;
  logic            skipTaken;
  logic            pcLoad;
  logic            stackPop;
  logic            globalIrqEnable;
  logic            sleepMode;
  logic            wdtClear;
  logic            wdtTimeout;
  logic            wakeReq;
  logic            regWr;
  logic            regRd;
  logic [PC_W-1:0] pcValue;
  logic [PC_W-1:0] stackTop;
  logic [PC_W-1:0] pc;
  logic [7:0]      workingReg;
  logic [7:0]      regWdata;
  logic [7:0]      regRdata;
  logic [7:0]      w;
  logic [7:0]      a;
  logic [7:0]      mem [256];
  logic [2:0]      regAddr;
  logic [5:0]      fl;
  logic            gie;
  mie_ins_s        ins;
  mie_flags_s      flags;
  int              fails = 0;
  int              compares = 0;
  int              cyc = 0;
  int              n;

  mie_execute dut (.sys_clk, .rst_n, .insValid, .insReady, .ins, .done,
    .skipTaken, .pcLoad, .pcValue, .stackPop, .stackTop, .workingReg,
    .flags, .globalIrqEnable, .sleepMode, .wdtClear, .wdtTimeout,
    .wakeReq, .regAddr, .regWdata, .regWr, .regRd, .regRdata);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // whole run needs well under 20000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input string s, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rst;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    w = 8'h00;
    fl = 6'h00;
    gie = 1'b0;
    pc = '0;
    @(negedge sys_clk);
    check("insReady", 16'(insReady), 16'h0001);
    check("state", {workingReg, 2'h0, flags}, 16'h0000);
    check("gie", 16'(globalIrqEnable), 16'h0000);
  endtask

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    if (ad == 0) w = d;
    if (ad == 1) fl = d[5:0];
    if (ad == 2) gie = d[0];
  endtask

  task automatic rd(input logic [2:0] ad);
    logic [7:0] e;
    e = ad == 0 ? w : ad == 1 ? {2'h0, fl} : ad == 2 ? {7'h00, gie}
      : ad == 3 ? pc[7:0] : ad == 4 ? {1'b0, pc[14:8]} : 8'h00;
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    check("regRdata", 16'(regRdata), 16'(e));
  endtask

  // pc reads only where its value is defined by reset or the last op
  task automatic rall(input bit p);
    for (int k = 0; k < 8; k++)
      if (p || (k != 3 && k != 4)) rd(k[2:0]);
  endtask

  task automatic ex(input mie_op_e op, input logic [7:0] ad, i,
                    input logic [2:0] b, input logic [PC_W-1:0] t);
    logic [7:0] m;
    logic [7:0] r;
    logic       sk;
    logic       pl;
    logic       sp;
    int         nb;
    int         sa;
    m = mem[ad];
    r = m;
    nb = fl[ST_CARRY] ? 0 : 1;
    case (op)
      OP_ADD_ONE, OP_ADD_ONE_W, OP_INC_SKIP, OP_INC_SKIP_W: r = m + 8'h01;
      OP_DEC_SKIP, OP_DEC_SKIP_W: r = m - 8'h01;
      OP_COPY_IW, OP_SUB_EXIT_IMM: r = i;
      OP_COPY_WM: r = w;
      OP_OR_M, OP_OR_TO_MEM: r = w | m;
      OP_OR_I: r = w | i;
      OP_LROT, OP_LROT_W: r = {m[6:0], m[7]};
      OP_LROT_C, OP_LROT_C_W: r = {m[6:0], fl[ST_CARRY]};
      OP_RROT, OP_RROT_W: r = {m[0], m[7:1]};
      OP_RROT_C, OP_RROT_C_W: r = {fl[ST_CARRY], m[7:1]};
      OP_SET_BYTE: r = BYTE_ONES;
      OP_SET_BIT: r[b] = 1'b1;
      OP_SUBB, OP_SUBB_MEM: begin
        sa = int'(w) - int'(m) - nb;
        r = sa[7:0];
        fl[ST_CARRY] = sa >= 0;
        fl[ST_HALF] = int'(w[3:0]) - int'(m[3:0]) - nb >= 0;
        sa = int'($signed(w)) - int'($signed(m)) - nb;
        fl[ST_EXCESS] = sa > 127 || sa < -128;
      end
      default: ;
    endcase
    if (op inside {OP_LROT_C, OP_LROT_C_W}) fl[ST_CARRY] = m[7];
    if (op inside {OP_RROT_C, OP_RROT_C_W}) fl[ST_CARRY] = m[0];
    if (op inside {OP_ADD_ONE, OP_ADD_ONE_W, OP_OR_M, OP_OR_I,
                   OP_OR_TO_MEM, OP_SUBB, OP_SUBB_MEM})
      fl[ST_ZERO] = r == 8'h00;
    if (op inside {OP_ADD_ONE, OP_COPY_WM, OP_OR_TO_MEM, OP_LROT,
                   OP_LROT_C, OP_RROT, OP_RROT_C, OP_SUBB_MEM,
                   OP_DEC_SKIP, OP_INC_SKIP, OP_SET_BYTE, OP_SET_BIT})
      mem[ad] = r;
    else if (!(op inside {OP_NOP, OP_BRANCH, OP_SUB_EXIT, OP_IRQ_EXIT}))
      w = r;
    sk = op inside {OP_DEC_SKIP, OP_DEC_SKIP_W, OP_INC_SKIP,
                    OP_INC_SKIP_W} && r == 8'h00;
    sp = op inside {OP_SUB_EXIT, OP_SUB_EXIT_IMM, OP_IRQ_EXIT};
    pl = sp || op == OP_BRANCH;
    if (pl) pc = t;
    if (op == OP_IRQ_EXIT) gie = 1'b1;
    @(negedge sys_clk);
    n = 0;
    while (insReady !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    insValid <= 1'b1;
    ins <= '{op, ad, i, b, t};
    stackTop <= t;
    @(posedge sys_clk);
    insValid <= 1'b0;
    nb = 0;
    for (n = 1; n < 5; n++) begin
      @(negedge sys_clk);
      if (stackPop === 1'b1) nb++;
      if (done === 1'b1) break;
    end
    check("cycles", 16'(n), (sk || pl) ? 16'h2 : 16'h1);
    check("skipTaken", 16'(skipTaken), 16'(sk));
    check("pcLoad", 16'(pcLoad), 16'(pl));
    check("stackPop", 16'(nb), 16'(sp));
    @(negedge sys_clk);
    check("workingReg", 16'(workingReg), 16'(w));
    check("flags", 16'(flags), 16'(fl));
    check("gie", 16'(globalIrqEnable), 16'(gie));
    if (pl) check("pcValue", 16'(pcValue), 16'(pc));
  endtask

  initial begin
    rst_n = 1'b0;
    insValid = 1'b0;
    ins = '0;
    stackTop = '0;
    wdtTimeout = 1'b0;
    wakeReq = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    void'($urandom(5));
    rst();
    rall(1'b1);
    // edge operands first: carry out of ff, borrow from 00 and 80
    for (int k = 0; k < 6; k++)
      for (int o = 0; o < int'(OP_SLEEP); o++) begin
        a = 8'($urandom);
        wr(3'h0, k == 0 ? 8'h00 : k == 1 ? 8'hff : k == 2 ? 8'h01
          : k == 3 ? 8'h80 : k == 4 ? 8'h7f : 8'($urandom));
        ex(OP_COPY_WM, a, 8'h00, 3'h0, '0);
        wr(3'h0, k == 0 ? 8'h00 : 8'($urandom));
        wr(3'h1, 8'($urandom) & 8'h0f);
        wr(3'h2, 8'h00);
        ex(mie_op_e'(o), a, 8'($urandom), 3'($urandom), 15'($urandom));
        rall(o >= int'(OP_BRANCH) && o <= int'(OP_IRQ_EXIT));
        ex(OP_COPY_MW, a, 8'h00, 3'h0, '0);
      end
    wr(3'h6, 8'h5a);
    @(posedge sys_clk);
    wdtTimeout <= 1'b1;
    @(posedge sys_clk);
    wdtTimeout <= 1'b0;
    fl[ST_WDT] = 1'b1;
    rall(1'b0);
    @(posedge sys_clk);
    insValid <= 1'b1;
    ins.op <= OP_SLEEP;
    @(posedge sys_clk);
    insValid <= 1'b0;
    n = 0;
    repeat (6) begin
      @(negedge sys_clk);
      if (wdtClear === 1'b1) n++;
      check("insReady", 16'(insReady), 16'h0000);
    end
    fl[ST_WDT] = 1'b0;
    fl[ST_SLEEP] = 1'b1;
    check("wdtClear", 16'(n), 16'h0001);
    check("sleepMode", 16'(sleepMode), 16'h0001);
    check("flags", 16'(flags), 16'(fl));
    @(posedge sys_clk);
    wakeReq <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (insReady !== 1'b1 && n < 10);
    @(posedge sys_clk);
    wakeReq <= 1'b0;
    @(negedge sys_clk);
    check("sleepMode", 16'(sleepMode), 16'h0000);
    rall(1'b0);
    ex(OP_COPY_MW, a, 8'h00, 3'h0, '0);
    rst();
    rall(1'b1);
    stop_test();
  end
endmodule

/* verilog/mie_execute.sv */
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module mie_execute
  import mie_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            insValid,
  output logic                 insReady,
  input  mie_ins_s             ins,
  output logic                 done,
  output logic                 skipTaken,
  output logic                 pcLoad,
  output logic      [PC_W-1:0] pcValue,
  output logic                 stackPop,
  input  wire logic [PC_W-1:0] stackTop,
  output logic      [7:0]      workingReg,
  output mie_flags_s           flags,
  output logic                 globalIrqEnable,
  output logic                 sleepMode,
  output logic                 wdtClear,
  input  wire logic            wdtTimeout,
  input  wire logic            wakeReq,
  input  wire logic [2:0]      regAddr,
  input  wire logic [7:0]      regWdata,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output logic      [7:0]      regRdata
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY, ST_SLEEP} mie_st_e;

  mie_st_e         state_q, state_d;
  mie_ins_s        insQ_q, insQ_d;
  logic [7:0]      work_q, work_d;
  mie_flags_s      flags_q, flags_d;
  logic            gie_q, gie_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            wake1_q, wake2_q;

  logic       memWr;
  logic [7:0] memWdata;
  logic [7:0] memRd;
  logic       twoCycle;
  logic [8:0] sub9;
  logic [4:0] sub5;
  logic [7:0] incr;
  logic [7:0] decr;
  logic [7:0] orRes;
  logic       isExec;

  mie_ram #(.W(DATA_W), .D(MEM_DEPTH), .AW(MEM_AW)) u_ram (
    .sys_clk (sys_clk),
    .wrEn    (memWr),
    .wrAddr  (insQ_q.addr),
    .wrData  (memWdata),
    .rdAddr  (ins.addr),
    .rdData  (memRd)
  );

  // arithmetic on the operand read from memory, or on the immediate for OP_OR_I
  assign sub9 = {1'b0, work_q} - {1'b0, memRd} - {8'h00, ~flags_q.carry};
  assign sub5 = {1'b0, work_q[3:0]} - {1'b0, memRd[3:0]}
              - {4'h0, ~flags_q.carry};
  assign incr = memRd + 8'h01;
  assign decr = memRd - 8'h01;
  assign orRes = work_q | ((insQ_q.op == OP_OR_I) ? insQ_q.imm : memRd);
  assign isExec = (state_q == ST_EXEC);

  assign insReady        = (state_q == ST_IDLE);
  assign sleepMode       = (state_q == ST_SLEEP);
  assign pcValue         = pc_q;
  assign workingReg      = work_q;
  assign flags           = flags_q;
  assign globalIrqEnable = gie_q;
  assign regRdata        = rdata_q;

  // dummy-cycle outputs depend on which kind of two-cycle op it was
  always_comb begin
    pcLoad    = 1'b0;
    skipTaken = 1'b0;
    done      = 1'b0;
    if (state_q == ST_DUMMY) begin
      done = 1'b1;
      if (insQ_q.op == OP_BRANCH || insQ_q.op == OP_SUB_EXIT ||
          insQ_q.op == OP_SUB_EXIT_IMM || insQ_q.op == OP_IRQ_EXIT) begin
        pcLoad = 1'b1;
      end else begin
        skipTaken = 1'b1;
      end
    end else if (isExec && !twoCycle) begin
      done = 1'b1;
    end
  end

  always_comb begin
    state_d  = state_q;
    insQ_d   = insQ_q;
    work_d   = work_q;
    flags_d  = flags_q;
    gie_d    = gie_q;
    pc_d     = pc_q;
    rdata_d  = 8'h00;
    memWr    = 1'b0;
    memWdata = 8'h00;
    stackPop = 1'b0;
    wdtClear = 1'b0;
    twoCycle = 1'b0;

    if (regRd) begin
      case (regAddr)
        REG_WORK:   rdata_d = work_q;
        REG_STATUS: rdata_d = {2'b00, flags_q};
        REG_CTRL:   rdata_d = {7'h00, gie_q};
        REG_PC_LO:  rdata_d = pc_q[7:0];
        REG_PC_HI:  rdata_d = {1'b0, pc_q[PC_W-1:8]};
        default:    rdata_d = 8'h00;
      endcase
    end
    // software writes lose to an instruction writing the same state
    if (regWr) begin
      case (regAddr)
        REG_WORK:   work_d = regWdata;
        REG_STATUS: flags_d = regWdata[ST_SLEEP:ST_CARRY];
        REG_CTRL:   gie_d = regWdata[CTRL_GIE];
        default:    ;
      endcase
    end

    case (state_q)
      ST_IDLE: begin
        if (insValid) begin
          insQ_d  = ins;
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (insQ_q.op)
          OP_NOP: ;
          OP_ADD_ONE: begin
            memWr        = 1'b1;
            memWdata     = incr;
            flags_d.zero = (incr == 8'h00);
          end
          OP_ADD_ONE_W: begin
            work_d       = incr;
            flags_d.zero = (incr == 8'h00);
          end
          OP_COPY_MW: work_d = memRd;
          OP_COPY_IW: work_d = insQ_q.imm;
          OP_COPY_WM: begin
            memWr    = 1'b1;
            memWdata = work_q;
          end
          OP_OR_M, OP_OR_I: begin
            work_d       = orRes;
            flags_d.zero = (orRes == 8'h00);
          end
          OP_OR_TO_MEM: begin
            memWr        = 1'b1;
            memWdata     = orRes;
            flags_d.zero = (orRes == 8'h00);
          end
          OP_BRANCH: begin
            pc_d     = insQ_q.target;
            twoCycle = 1'b1;
          end
          OP_SUB_EXIT, OP_SUB_EXIT_IMM, OP_IRQ_EXIT: begin
            stackPop = 1'b1;
            pc_d     = stackTop;
            twoCycle = 1'b1;
            if (insQ_q.op == OP_SUB_EXIT_IMM) begin
              work_d = insQ_q.imm;
            end
            if (insQ_q.op == OP_IRQ_EXIT) begin
              gie_d = 1'b1;
            end
          end
          OP_LROT: begin
            memWr    = 1'b1;
            memWdata = {memRd[6:0], memRd[7]};
          end
          OP_LROT_W: work_d = {memRd[6:0], memRd[7]};
          OP_LROT_C, OP_LROT_C_W: begin
            flags_d.carry = memRd[7];
            if (insQ_q.op == OP_LROT_C) begin
              memWr    = 1'b1;
              memWdata = {memRd[6:0], flags_q.carry};
            end else begin
              work_d = {memRd[6:0], flags_q.carry};
            end
          end
          OP_RROT: begin
            memWr    = 1'b1;
            memWdata = {memRd[0], memRd[7:1]};
          end
          OP_RROT_W: work_d = {memRd[0], memRd[7:1]};
          OP_RROT_C, OP_RROT_C_W: begin
            flags_d.carry = memRd[0];
            if (insQ_q.op == OP_RROT_C) begin
              memWr    = 1'b1;
              memWdata = {flags_q.carry, memRd[7:1]};
            end else begin
              work_d = {flags_q.carry, memRd[7:1]};
            end
          end
          OP_SUBB, OP_SUBB_MEM: begin
            if (insQ_q.op == OP_SUBB) begin
              work_d = sub9[7:0];
            end else begin
              memWr    = 1'b1;
              memWdata = sub9[7:0];
            end
            flags_d.carry     = ~sub9[8];
            flags_d.halfCarry = ~sub5[4];
            flags_d.zero      = (sub9[7:0] == 8'h00);
            flags_d.excess    = (work_q[7] != memRd[7]) &&
                                (sub9[7] != work_q[7]);
          end
          OP_DEC_SKIP: begin
            memWr    = 1'b1;
            memWdata = decr;
            twoCycle = (decr == 8'h00);
          end
          OP_DEC_SKIP_W: begin
            work_d   = decr;
            twoCycle = (decr == 8'h00);
          end
          OP_INC_SKIP: begin
            memWr    = 1'b1;
            memWdata = incr;
            twoCycle = (incr == 8'h00);
          end
          OP_INC_SKIP_W: begin
            work_d   = incr;
            twoCycle = (incr == 8'h00);
          end
          OP_SET_BYTE: begin
            memWr    = 1'b1;
            memWdata = BYTE_ONES;
          end
          OP_SET_BIT: begin
            memWr    = 1'b1;
            memWdata = memRd | (8'h01 << insQ_q.bitSel);
          end
          OP_SLEEP: begin
            wdtClear             = 1'b1;
            flags_d.sleepEntered = 1'b1;
            flags_d.wdtExpiry    = 1'b0;
          end
          default: ;
        endcase
        if (insQ_q.op == OP_SLEEP) begin
          state_d = ST_SLEEP;
        end else if (twoCycle) begin
          state_d = ST_DUMMY;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_DUMMY: state_d = ST_IDLE;
      ST_SLEEP: begin
        if (wake2_q) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    // a time-out in the same cycle as a clear still lands
    if (wdtTimeout) begin
      flags_d.wdtExpiry = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      insQ_q  <= '0;
      work_q  <= WORK_RST;
      flags_q <= '0;
      gie_q   <= GIE_RST;
      pc_q    <= PC_RST;
      rdata_q <= 8'h00;
      wake1_q <= 1'b0;
      wake2_q <= 1'b0;
    end else begin
      state_q <= state_d;
      insQ_q  <= insQ_d;
      work_q  <= work_d;
      flags_q <= flags_d;
      gie_q   <= gie_d;
      pc_q    <= pc_d;
      rdata_q <= rdata_d;
      wake1_q <= wakeReq;
      wake2_q <= wake1_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_add_one;
    isExec && insQ_q.op == OP_ADD_ONE |-> memWr && memWdata == memRd + 8'h01;
  endproperty
  a_add_one: assert property (p_add_one)
    else $error("add-one did not write operand plus one");

  property p_branch;
    isExec && insQ_q.op == OP_BRANCH |=>
      pcLoad && done && pcValue == $past(insQ_q.target) ##1 !pcLoad;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch did not load target over two cycles");

  property p_copy_flags;
    isExec && insQ_q.op inside {OP_COPY_MW, OP_COPY_IW, OP_COPY_WM}
      && !regWr |=> flags_q[3:0] == $past(flags_q[3:0]);
  endproperty
  a_copy_flags: assert property (p_copy_flags)
    else $error("copy changed a flag");

  property p_or_zero;
    isExec && insQ_q.op == OP_OR_M |=>
      workingReg == ($past(work_q) | $past(memRd)) &&
      flags_q.zero == (workingReg == 8'h00);
  endproperty
  a_or_zero: assert property (p_or_zero)
    else $error("or result or zero flag wrong");

  property p_exit_pop;
    isExec && insQ_q.op == OP_SUB_EXIT |-> stackPop ##1
      pcLoad && pcValue == $past(stackTop);
  endproperty
  a_exit_pop: assert property (p_exit_pop)
    else $error("exit did not restore pc from stack");

  property p_irq_exit;
    isExec && insQ_q.op == OP_IRQ_EXIT |=> globalIrqEnable;
  endproperty
  a_irq_exit: assert property (p_irq_exit)
    else $error("interrupt exit left global enable low");

  property p_lrot_c;
    isExec && insQ_q.op == OP_LROT_C |->
      memWdata == {memRd[6:0], flags_q.carry} ##1
      flags_q.carry == $past(memRd[7]);
  endproperty
  a_lrot_c: assert property (p_lrot_c)
    else $error("left rotate via carry wrong");

  property p_sub_carry;
    isExec && insQ_q.op == OP_SUBB |=> flags_q.carry ==
      ($past(work_q) > $past(memRd) ||
       ($past(work_q) == $past(memRd) && $past(flags_q.carry)));
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("carry after subtraction wrong");

  property p_skip;
    isExec && insQ_q.op == OP_DEC_SKIP && memRd == 8'h01 |=>
      skipTaken && done ##1 !skipTaken && insReady;
  endproperty
  a_skip: assert property (p_skip)
    else $error("taken skip did not insert one dummy cycle");

  property p_sleep;
    isExec && insQ_q.op == OP_SLEEP && !wdtTimeout |-> wdtClear ##1
      sleepMode && flags_q.sleepEntered && !flags_q.wdtExpiry;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("power-down entry flags wrong");

  property p_set_byte;
    isExec && insQ_q.op == OP_SET_BYTE |-> memWr && memWdata == BYTE_ONES;
  endproperty
  a_set_byte: assert property (p_set_byte)
    else $error("byte set did not write all ones");

  c_branch: cover property (isExec && insQ_q.op == OP_BRANCH);
  c_skip:   cover property (skipTaken);
  c_sleep:  cover property (sleepMode ##1 !sleepMode);
  c_subb:   cover property (isExec && insQ_q.op == OP_SUBB_MEM);

endmodule

/* verilog/mie_pkg.sv */
package mie_pkg;

  localparam int DATA_W    = 8;
  localparam int PC_W      = 15;
  localparam int MEM_DEPTH = 256;
  localparam int MEM_AW    = 8;

  // register port offsets
  localparam logic [2:0] REG_WORK   = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CTRL   = 3'h2;
  localparam logic [2:0] REG_PC_LO  = 3'h3;
  localparam logic [2:0] REG_PC_HI  = 3'h4;

  // status and control field positions
  localparam int ST_CARRY  = 0;
  localparam int ST_HALF   = 1;
  localparam int ST_ZERO   = 2;
  localparam int ST_EXCESS = 3;
  localparam int ST_WDT    = 4;
  localparam int ST_SLEEP  = 5;
  localparam int CTRL_GIE  = 0;

  // reset values, and the all-ones byte
  localparam logic [7:0]      WORK_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST   = 15'h0000;
  localparam logic            GIE_RST  = 1'b0;
  localparam logic [7:0]      BYTE_ONES = 8'hff;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_ONE, OP_ADD_ONE_W,
    OP_COPY_MW, OP_COPY_IW, OP_COPY_WM,
    OP_OR_M, OP_OR_I, OP_OR_TO_MEM,
    OP_BRANCH, OP_SUB_EXIT, OP_SUB_EXIT_IMM, OP_IRQ_EXIT,
    OP_LROT, OP_LROT_W, OP_LROT_C, OP_LROT_C_W,
    OP_RROT, OP_RROT_W, OP_RROT_C, OP_RROT_C_W,
    OP_SUBB, OP_SUBB_MEM,
    OP_DEC_SKIP, OP_DEC_SKIP_W, OP_INC_SKIP, OP_INC_SKIP_W,
    OP_SET_BYTE, OP_SET_BIT, OP_SLEEP
  } mie_op_e;

  typedef struct packed {
    mie_op_e         op;
    logic [7:0]      addr;
    logic [7:0]      imm;
    logic [2:0]      bitSel;
    logic [PC_W-1:0] target;
  } mie_ins_s;

  typedef struct packed {
    logic sleepEntered;
    logic wdtExpiry;
    logic excess;
    logic zero;
    logic halfCarry;
    logic carry;
  } mie_flags_s;

endpackage

/* verilog/mie_ram.sv */
`timescale 1ns/10ps
module mie_ram #(
  parameter int W  = 8,
  parameter int D  = 256,
  parameter int AW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [W-1:0]  rdData
);
  logic [W-1:0] mem [D];

  // read data registered; no reset so it maps onto block memory
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
